// ==== hdl/rpmic_top.sv ====
// Purpose: Registers and interrupt of eight receive frame pattern matchers.
// Assumes: Frame results arrive on aclk from the receive path; software uses AXI4-Lite.
// Notes: Pending flags are write-one-to-clear; a new event wins over a clear.
`timescale 1ns/100ps
module rpmic_top (
   // Clock, reset and enable.
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write address and data.
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response.
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address.
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   // AXI4-Lite read data.
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Receive path frame result.
   input wire logic frame_done,
   input wire logic frame_crc_ok,
   input wire logic frame_mac_drop,
   input wire logic [95:0] frame_head,
   // Pattern interrupt.
   output logic pattern_irq_out
);

   logic aw_full;
   logic w_full;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [31:0] rd_addr;
   rpmic_pkg::rpmic_rd_e rd_state;
   logic [7:0] match_irq_enables;
   logic [7:0] match_pending_flags;
   logic [7:0] per_pattern_match_bits;
   logic [2:0] pattern_selector;
   logic [7:0] hit;
   logic [7:0] pend_clr;
   logic [7:0] next_pending;
   logic wr_commit;
   logic ar_take;
   logic frame_ok;
   rpmic_pkg::rpmic_reg_e wr_reg;
   rpmic_pkg::rpmic_reg_e rd_reg;
   rpmic_pkg::rpmic_reg_e ar_reg;
   logic mem_wr;
   logic mem_rd;
   logic [5:0] mem_wr_idx;
   logic [5:0] mem_rd_idx;
   logic [31:0] mem_rd_data;
   logic [31:0] rd_mux;
   logic [rpmic_pkg::NUM_PAT*rpmic_pkg::PAT_BITS-1:0] cmp_flat;
   logic [rpmic_pkg::NUM_PAT*rpmic_pkg::PAT_BITS-1:0] msk_flat;

   // Decode and strobes of the bus side; a write commits once address and data are both held.
   always_comb begin
      wr_commit = aw_full && w_full && !bvalid;
      ar_take = arvalid && arready;
      wr_reg = rpmic_pkg::decode(aw_addr);
      rd_reg = rpmic_pkg::decode(rd_addr);
      ar_reg = rpmic_pkg::decode(araddr);
      mem_wr = wr_commit && wr_reg == rpmic_pkg::REG_WIN;
      mem_rd = ar_take && ar_reg == rpmic_pkg::REG_WIN;
      mem_wr_idx = rpmic_pkg::mem_index(pattern_selector, rpmic_pkg::win_word(aw_addr));
      mem_rd_idx = rpmic_pkg::mem_index(pattern_selector, rpmic_pkg::win_word(araddr));
      pend_clr = 8'h00;
      if (wr_commit && wr_reg == rpmic_pkg::REG_PEND && w_strb[0]) begin
         pend_clr = w_data[7:0];
      end
   end

   // Pattern storage behind the selector window.
   rpmic_pattern_store u_store (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .wr_en(mem_wr),
      .wr_idx(mem_wr_idx),
      .wr_strb(w_strb),
      .wr_data(w_data),
      .rd_en(mem_rd),
      .rd_idx(mem_rd_idx),
      .rd_data(mem_rd_data),
      .cmp_flat(cmp_flat),
      .msk_flat(msk_flat)
   );

   // Write address channel; only one write is held at a time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         awready <= 1'b1;
         aw_addr <= 32'h00000000;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_full <= 1'b1;
            awready <= 1'b0;
            aw_addr <= awaddr;
         end else if (wr_commit) begin
            aw_full <= 1'b0;
            awready <= 1'b1;
         end
      end
   end

   // Write data channel, taken independently of the address.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         wready <= 1'b1;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (ce) begin
         if (wvalid && wready) begin
            w_full <= 1'b1;
            wready <= 1'b0;
            w_data <= wdata;
            w_strb <= wstrb;
         end else if (wr_commit) begin
            w_full <= 1'b0;
            wready <= 1'b1;
         end
      end
   end

   // Write response; unmapped addresses get SLVERR, the read-only status word is ignored.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= rpmic_pkg::RESP_OKAY;
      end else if (ce) begin
         if (wr_commit) begin
            bvalid <= 1'b1;
            bresp <= (wr_reg == rpmic_pkg::REG_NONE) ? rpmic_pkg::RESP_SLVERR
                                                    : rpmic_pkg::RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read data selection; reserved bits read as zero.
   always_comb begin
      case (rd_reg)
         rpmic_pkg::REG_ENA: rd_mux = {24'h000000, match_irq_enables};
         rpmic_pkg::REG_PEND: rd_mux = {24'h000000, match_pending_flags};
         rpmic_pkg::REG_GSTAT: rd_mux = {31'h00000000, pattern_irq_out};
         rpmic_pkg::REG_SEL: rd_mux = {29'h00000000, pattern_selector};
         rpmic_pkg::REG_WIN: rd_mux = mem_rd_data;
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Read channel: the store needs one cycle, so data answer two cycles after the address.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= rpmic_pkg::RD_IDLE;
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= rpmic_pkg::RESP_OKAY;
         rd_addr <= 32'h00000000;
      end else if (ce) begin
         case (rd_state)
            rpmic_pkg::RD_IDLE: begin
               if (ar_take) begin
                  rd_addr <= araddr;
                  arready <= 1'b0;
                  rd_state <= rpmic_pkg::RD_FETCH;
               end
            end
            rpmic_pkg::RD_FETCH: begin
               rdata <= rd_mux;
               rresp <= (rd_reg == rpmic_pkg::REG_NONE) ? rpmic_pkg::RESP_SLVERR
                                                       : rpmic_pkg::RESP_OKAY;
               rvalid <= 1'b1;
               rd_state <= rpmic_pkg::RD_RESP;
            end
            rpmic_pkg::RD_RESP: begin
               if (rready) begin
                  rvalid <= 1'b0;
                  arready <= 1'b1;
                  rd_state <= rpmic_pkg::RD_IDLE;
               end
            end
            default: begin
               rvalid <= 1'b0;
               arready <= 1'b1;
               rd_state <= rpmic_pkg::RD_IDLE;
            end
         endcase
      end
   end

   // Enable and selector registers; only byte lane 0 carries implemented bits.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match_irq_enables <= rpmic_pkg::RST_ENABLES;
         pattern_selector <= rpmic_pkg::RST_SEL;
      end else if (ce && wr_commit && w_strb[0]) begin
         if (wr_reg == rpmic_pkg::REG_ENA) begin
            match_irq_enables <= w_data[7:0];
         end
         if (wr_reg == rpmic_pkg::REG_SEL) begin
            pattern_selector <= w_data[2:0];
         end
      end
   end

   // One comparator per pattern; mask bits that are set take part in the compare.
   for (genvar p = 0; p < rpmic_pkg::NUM_PAT; p++) begin : g_match
      assign hit[p] = ((frame_head ^ cmp_flat[p*96 +: 96]) & msk_flat[p*96 +: 96]) == 96'h0;
   end

   // A frame counts only once its CRC check is done and the MAC kept it; later switch
   // drops and the receiving port play no part here.
   assign frame_ok = frame_done && frame_crc_ok && !frame_mac_drop;

   // Match events are registered so the pending update sees a clean one-cycle pulse.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         per_pattern_match_bits <= 8'h00;
      end else if (ce) begin
         per_pattern_match_bits <= frame_ok ? hit : 8'h00;
      end
   end

   // Sticky pending flags, independent of enables; a set in the clearing cycle survives.
   assign next_pending = (match_pending_flags & ~pend_clr) | per_pattern_match_bits;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match_pending_flags <= rpmic_pkg::RST_PENDING;
      end else if (ce) begin
         match_pending_flags <= next_pending;
      end
   end

   // Level interrupt while any enabled flag is pending; also read back as global status.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pattern_irq_out <= 1'b0;
      end else if (ce) begin
         pattern_irq_out <= |(match_pending_flags & match_irq_enables);
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Steps of a read and of a frame result.
   sequence s_ar_take;
      ce && arvalid && arready;
   endsequence

   sequence s_good_frame;
      ce && frame_done && frame_crc_ok && !frame_mac_drop;
   endsequence

   sequence s_bad_frame;
      ce && frame_done && (!frame_crc_ok || frame_mac_drop);
   endsequence

   irq_level_a: assert property (ce |=> pattern_irq_out ==
         $past(|(match_pending_flags & match_irq_enables)))
      else $error("Interrupt output does not follow enabled pending flags.");

   irq_hold_a: assert property ($past(ce, 2) && $past(ce) && ce && !pattern_irq_out &&
         $past(pattern_irq_out) |-> $past(pend_clr, 2) != 8'h00 ||
         $past(match_irq_enables) != $past(match_irq_enables, 2))
      else $error("Interrupt dropped without a clear or disable.");

   good_frame_a: assert property (s_good_frame ##1 ce |=>
         (match_pending_flags & $past(hit, 2)) == $past(hit, 2))
      else $error("Matching good frame did not set its pending flags.");

   bad_frame_a: assert property (s_bad_frame |=> per_pattern_match_bits == 8'h00)
      else $error("Match event raised for a frame discarded by the MAC.");

   pend_sticky_a: assert property (ce |=>
         ((~match_pending_flags & $past(match_pending_flags)) & ~$past(pend_clr)) == 8'h00)
      else $error("Pending flag fell without a one written to it.");

   set_wins_a: assert property (ce && (pend_clr & per_pattern_match_bits) != 8'h00 |=>
         (match_pending_flags & $past(per_pattern_match_bits)) == $past(per_pattern_match_bits))
      else $error("Clear in the event cycle lost the event.");

   latch_disabled_a: assert property (ce && (per_pattern_match_bits & ~match_irq_enables) != 8'h00
         |=> (match_pending_flags & $past(per_pattern_match_bits)) != 8'h00)
      else $error("Event of a disabled pattern was not latched.");

   rd_latency_a: assert property (s_ar_take ##1 ce |=> rvalid)
      else $error("Read answer not given two cycles after the address.");

   sel_reserved_a: assert property (rvalid && $rose(rvalid) && rd_reg == rpmic_pkg::REG_SEL
         |-> rdata[31:3] == 29'h00000000)
      else $error("Reserved selector bits read as nonzero.");

   reset_zero_a: assert property (disable iff (1'b0) !aresetn |=>
         match_pending_flags == 8'h00 && match_irq_enables == 8'h00 && pattern_selector == 3'h0)
      else $error("Configuration not zero after reset.");

endmodule : rpmic_top

// ==== pkg/rpmic_pkg.sv ====
// Purpose: Shared constants and types of the receive pattern match configuration block.
// Assumes: One clock, AXI4-Lite register access with full 32-bit byte addresses.
// Notes: The pattern store keeps three compare words, then three mask words, per pattern.
package rpmic_pkg;

   // Geometry of the pattern store.
   localparam int NUM_PAT = 8;
   localparam int PAT_BITS = 96;
   localparam int PAT_WORDS = 6;
   localparam int CMP_WORDS = 3;
   localparam int DEPTH = NUM_PAT * PAT_WORDS;

   // Register byte addresses.
   localparam logic [31:0] ADDR_ENABLES = 32'h44053ED0;
   localparam logic [31:0] ADDR_PENDING = 32'h44053ED4;
   localparam logic [31:0] ADDR_GSTAT = 32'h44053ED8;
   localparam logic [31:0] ADDR_SEL = 32'h44053EDC;
   localparam logic [31:0] ADDR_CMP_0_3 = 32'h44053EE0;
   localparam logic [31:0] ADDR_CMP_4_7 = 32'h44053EE4;
   localparam logic [31:0] ADDR_CMP_8_11 = 32'h44053EE8;
   localparam logic [31:0] ADDR_MSK_0_3 = 32'h44053EF0;
   localparam logic [31:0] ADDR_MSK_4_7 = 32'h44053EF4;
   localparam logic [31:0] ADDR_MSK_8_11 = 32'h44053EF8;

   // Values after reset.
   localparam logic [7:0] RST_ENABLES = 8'h00;
   localparam logic [7:0] RST_PENDING = 8'h00;
   localparam logic [2:0] RST_SEL = 3'h0;
   localparam logic [31:0] RST_WORD = 32'h00000000;

   // Bus answers.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register identities after address decode.
   typedef enum logic [2:0] {REG_NONE, REG_ENA, REG_PEND, REG_GSTAT, REG_SEL, REG_WIN} rpmic_reg_e;

   // Read channel states.
   typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} rpmic_rd_e;

   // Maps a byte address onto a register identity.
   function automatic rpmic_reg_e decode(input logic [31:0] addr);
      case (addr)
         ADDR_ENABLES: decode = REG_ENA;
         ADDR_PENDING: decode = REG_PEND;
         ADDR_GSTAT: decode = REG_GSTAT;
         ADDR_SEL: decode = REG_SEL;
         ADDR_CMP_0_3, ADDR_CMP_4_7, ADDR_CMP_8_11: decode = REG_WIN;
         ADDR_MSK_0_3, ADDR_MSK_4_7, ADDR_MSK_8_11: decode = REG_WIN;
         default: decode = REG_NONE;
      endcase
   endfunction : decode

   // Word of a pattern: 0 to 2 compare, 3 to 5 mask.
   function automatic logic [2:0] win_word(input logic [31:0] addr);
      logic [2:0] w;
      w = 3'(addr[3:2]);
      win_word = addr[4] ? 3'(w + 3'h3) : w;
   endfunction : win_word

   // Store index of one word of the selected pattern.
   function automatic logic [5:0] mem_index(input logic [2:0] sel, input logic [2:0] word);
      mem_index = 6'({3'h0, sel} * 6'h06) + {3'h0, word};
   endfunction : mem_index

endpackage : rpmic_pkg

// ==== hdl/rpmic_pattern_store.sv ====
// Purpose: Compare and mask storage of all eight patterns.
// Assumes: One write and one read port, both on aclk.
// Notes: Every word is also exposed flat so all comparators work in parallel.
`timescale 1ns/100ps
module rpmic_pattern_store (
   // Clock, reset and enable.
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Write port with byte enables.
   input wire logic wr_en,
   input wire logic [5:0] wr_idx,
   input wire logic [3:0] wr_strb,
   input wire logic [31:0] wr_data,
   // Read port, data one cycle after the request.
   input wire logic rd_en,
   input wire logic [5:0] rd_idx,
   output logic [31:0] rd_data,
   // Whole contents for the comparators.
   output logic [rpmic_pkg::NUM_PAT*rpmic_pkg::PAT_BITS-1:0] cmp_flat,
   output logic [rpmic_pkg::NUM_PAT*rpmic_pkg::PAT_BITS-1:0] msk_flat
);

   logic [31:0] mem [rpmic_pkg::DEPTH];

   // One storage word per entry, byte lanes written separately.
   for (genvar w = 0; w < rpmic_pkg::DEPTH; w++) begin : g_word
      logic [31:0] word;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            word <= rpmic_pkg::RST_WORD;
         end else if (ce && wr_en && wr_idx == 6'(w)) begin
            for (int b = 0; b < 4; b++) begin
               if (wr_strb[b]) begin
                  word[b*8 +: 8] <= wr_data[b*8 +: 8];
               end
            end
         end
      end
      assign mem[w] = word;
      if ((w % rpmic_pkg::PAT_WORDS) < rpmic_pkg::CMP_WORDS) begin : g_cmp
         assign cmp_flat[(w / 6) * 96 + (w % 6) * 32 +: 32] = word;
      end else begin : g_msk
         assign msk_flat[(w / 6) * 96 + ((w % 6) - 3) * 32 +: 32] = word;
      end
   end

   // Registered read keeps the bus path short.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_data <= rpmic_pkg::RST_WORD;
      end else if (ce && rd_en) begin
         rd_data <= mem[rd_idx];
      end
   end

endmodule : rpmic_pattern_store

// ==== dv/rpmic_rx_model.sv ====
// Purpose: Receive path model that hands frame results to the pattern block.
// Assumes: Results are offered only once the MAC has finished its CRC check.
// Notes: Released lines show the inverse of the last value, never a stale copy.
`timescale 1ns/100ps
module rpmic_rx_model (
   // Clock.
   input wire logic aclk,
   // Frame result.
   output logic frame_done,
   output logic frame_crc_ok,
   output logic frame_mac_drop,
   output logic [95:0] frame_head
);
   // Lines start quiet so the block sees no result at time zero.
   initial begin
      frame_done = 1'b0;
      frame_crc_ok = 1'b0;
      frame_mac_drop = 1'b0;
      frame_head = 96'h0;
   end

   // One result pulse; the qualifiers are only valid in the pulse cycle.
   task send(input logic [95:0] head, input logic crc_ok, input logic drop);
      @(posedge aclk);
      frame_done <= 1'b1;
      frame_head <= head;
      frame_crc_ok <= crc_ok;
      frame_mac_drop <= drop;
      @(posedge aclk);
      frame_done <= 1'b0;
      frame_head <= ~head;
      frame_crc_ok <= ~crc_ok;
      frame_mac_drop <= ~drop;
   endtask : send
endmodule : rpmic_rx_model

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench of the pattern match configuration block.
// Assumes: Register reads and writes answer within the bench's cycle ceiling.
// Notes: Expected bus answers are queued by the drivers and popped by a monitor.
`timescale 1ns/100ps
module tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic frame_done, frame_crc_ok, frame_mac_drop;
   logic [95:0] frame_head;
   logic [33:0] wq[$];
   logic [33:0] rq[$];
   logic [31:0] mem[8][6];
   logic [95:0] head;
   logic [7:0] pend_exp, en;
   int errors = 0, checks = 0, cycles = 0, seed = 2;

   rpmic_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .frame_done(frame_done), .frame_crc_ok(frame_crc_ok),
      .frame_mac_drop(frame_mac_drop), .frame_head(frame_head), .pattern_irq_out(irq));

   rpmic_rx_model i_rx (.aclk(aclk), .frame_done(frame_done), .frame_crc_ok(frame_crc_ok),
      .frame_mac_drop(frame_mac_drop), .frame_head(frame_head));

   // Clock of 50 ns period.
   initial begin
      forever #25 aclk = ~aclk;
   end

   // Compares one value and counts the outcome.
   task check(input string name, input logic [33:0] seen, input logic [33:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Prints the counts and the verdict, then stops.
   task end_sim;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   // Byte address of word w of the selected pattern: three compare, then three mask.
   function automatic logic [31:0] waddr(input int w);
      waddr = (w < 3) ? rpmic_pkg::ADDR_CMP_0_3 + 32'(4 * w)
                      : rpmic_pkg::ADDR_MSK_0_3 + 32'(4 * (w - 3));
   endfunction : waddr

   // Match vector of all patterns for one frame head, from the stored model.
   function automatic logic [7:0] hits(input logic [95:0] h);
      logic [95:0] c, m;
      for (int p = 0; p < 8; p++) begin
         c = {mem[p][2], mem[p][1], mem[p][0]};
         m = {mem[p][5], mem[p][4], mem[p][3]};
         hits[p] = ((h ^ c) & m) == 96'h0;
      end
   endfunction : hits

   // AXI4-Lite write; address and data offered together, each released when taken.
   task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] resp);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      wq.push_back({32'h0, resp});
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b0;
   endtask : axi_wr

   // AXI4-Lite read; the expected data and response are queued for the monitor.
   task axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] resp);
      rq.push_back({d, resp});
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rready <= 1'b0;
   endtask : axi_rd

   // Monitor: every completed response is compared with the oldest queued note.
   always @(posedge aclk) begin
      if (bvalid === 1'b1 && bready === 1'b1) begin
         if (wq.size() == 0) check("bresp_extra", 34'h1, 34'h0);
         else check("bresp", {32'h0, bresp}, wq.pop_front());
      end
      if (rvalid === 1'b1 && rready === 1'b1) begin
         if (rq.size() == 0) check("read_extra", 34'h1, 34'h0);
         else check("read", {rdata, rresp}, rq.pop_front());
      end
   end

   // Hang guard; the whole sequence needs under a thousand cycles.
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_sim();
      end
   end

   // Main sequence.
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      // Pattern 0, enables, pending and selector read zero after reset; an unmapped word answers with an error.
      for (int w = 0; w < 6; w++) axi_rd(waddr(w), 32'h0, rpmic_pkg::RESP_OKAY);
      axi_rd(rpmic_pkg::ADDR_ENABLES, 32'h0, rpmic_pkg::RESP_OKAY);
      axi_rd(rpmic_pkg::ADDR_PENDING, 32'h0, rpmic_pkg::RESP_OKAY);
      axi_rd(rpmic_pkg::ADDR_SEL, 32'h0, rpmic_pkg::RESP_OKAY);
      axi_rd(32'h44053EEC, 32'h0, rpmic_pkg::RESP_SLVERR);
      axi_wr(32'h44053EEC, 32'hFFFFFFFF, rpmic_pkg::RESP_SLVERR);
      // Fill every pattern through the window, then read all back in reverse order.
      for (int p = 0; p < 8; p++) begin
         axi_wr(rpmic_pkg::ADDR_SEL, 32'hFFFFFFF8 | 32'(p), rpmic_pkg::RESP_OKAY);
         axi_rd(rpmic_pkg::ADDR_SEL, 32'(p), rpmic_pkg::RESP_OKAY);
         for (int w = 0; w < 6; w++) begin
            mem[p][w] = $random(seed);
            axi_wr(waddr(w), mem[p][w], rpmic_pkg::RESP_OKAY);
         end
      end
      for (int p = 7; p >= 0; p--) begin
         axi_wr(rpmic_pkg::ADDR_SEL, 32'(p), rpmic_pkg::RESP_OKAY);
         for (int w = 0; w < 6; w++) axi_rd(waddr(w), mem[p][w], rpmic_pkg::RESP_OKAY);
      end
      // Frames matching each pattern, unmasked bits flipped; enables all off.
      pend_exp = 8'h00;
      for (int p = 0; p < 8; p++) begin
         head = {mem[p][2], mem[p][1], mem[p][0]} ^
                ({$random(seed), $random(seed), $random(seed)} & ~{mem[p][5], mem[p][4], mem[p][3]});
         i_rx.send(head, 1'b0, 1'b0);
         i_rx.send(head, 1'b1, 1'b1);
         repeat (4) @(posedge aclk);
         check("pending_bad_frame", {26'h0, pend_exp}, {26'h0, i_dut.match_pending_flags});
         i_rx.send(head, 1'b1, 1'b0);
         pend_exp = pend_exp | hits(head);
         repeat (4) @(posedge aclk);
         check("irq_disabled", {33'h0, irq}, 34'h0);
         axi_rd(rpmic_pkg::ADDR_PENDING, {24'h0, pend_exp}, rpmic_pkg::RESP_OKAY);
      end
      // Random enables raise the output; writing zero keeps flags, ones clear them.
      en = 8'($random(seed)) | 8'h01;
      axi_wr(rpmic_pkg::ADDR_ENABLES, 32'hA5A5A500 | 32'(en), rpmic_pkg::RESP_OKAY);
      axi_rd(rpmic_pkg::ADDR_ENABLES, {24'h0, en}, rpmic_pkg::RESP_OKAY);
      repeat (3) @(posedge aclk);
      check("irq_enabled", {33'h0, irq}, {33'h0, |(pend_exp & en)});
      axi_rd(rpmic_pkg::ADDR_GSTAT, {31'h0, |(pend_exp & en)}, rpmic_pkg::RESP_OKAY);
      axi_wr(rpmic_pkg::ADDR_PENDING, 32'hFFFFFF00, rpmic_pkg::RESP_OKAY);
      axi_rd(rpmic_pkg::ADDR_PENDING, {24'h0, pend_exp}, rpmic_pkg::RESP_OKAY);
      for (int p = 0; p < 8; p++) begin
         axi_wr(rpmic_pkg::ADDR_PENDING, 32'h1 << p, rpmic_pkg::RESP_OKAY);
         pend_exp[p] = 1'b0;
         repeat (3) @(posedge aclk);
         check("irq_after_clear", {33'h0, irq}, {33'h0, |(pend_exp & en)});
         axi_rd(rpmic_pkg::ADDR_PENDING, {24'h0, pend_exp}, rpmic_pkg::RESP_OKAY);
      end
      // A clear and an event of the same pattern land in one cycle: the event survives.
      pend_exp = hits(head);
      fork
         axi_wr(rpmic_pkg::ADDR_PENDING, {24'h0, pend_exp}, rpmic_pkg::RESP_OKAY);
         i_rx.send(head, 1'b1, 1'b0);
      join
      repeat (3) @(posedge aclk);
      check("irq_set_wins", {33'h0, irq}, {33'h0, |(pend_exp & en)});
      axi_rd(rpmic_pkg::ADDR_PENDING, {24'h0, pend_exp}, rpmic_pkg::RESP_OKAY);
      repeat (4) @(posedge aclk);
      end_sim();
   end
endmodule : tb_top
